//--- include/epsr_pkg.sv
// constants and types for the exception pending state register block
package epsr_pkg;

	// register byte offsets on the bus
	localparam logic [3:0] OFS_ICS    = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_MASK   = 4'h8;
	localparam logic [3:0] OFS_PRIO   = 4'hc;

	// interrupt_control_state field positions
	localparam int unsigned BIT_DSV_SET    = 28;
	localparam int unsigned BIT_DSV_CLR    = 27;
	localparam int unsigned BIT_TICK_SET   = 26;
	localparam int unsigned BIT_TICK_CLR   = 25;
	localparam int unsigned BIT_ANY_PEND   = 22;
	localparam int unsigned POS_HIGH_PEND  = 12;
	localparam int unsigned POS_ACTIVE     = 0;
	localparam int unsigned EXC_NUM_W      = 6;

	// event status / mask bit positions
	localparam int unsigned EV_TICK_SET   = 0;
	localparam int unsigned EV_DSV_SET    = 1;
	localparam int unsigned EV_ACTIVE_CHG = 2;
	localparam int unsigned EV_W          = 3;

	// priority register field positions (two bits each)
	localparam int unsigned POS_PRIO_DSV  = 0;
	localparam int unsigned POS_PRIO_TICK = 2;
	localparam int unsigned PRIO_W        = 2;

	// exception numbers
	localparam logic [5:0] EXC_NONE      = 6'h00;
	localparam logic [5:0] EXC_DSV       = 6'h0e;
	localparam logic [5:0] EXC_TICK      = 6'h0f;
	localparam logic [5:0] EXC_EXT_BASE  = 6'h10;
	localparam int unsigned EXT_IRQS     = 32;

	// reset values
	localparam logic [EV_W-1:0]     RST_MASK = 3'h0;
	localparam logic [2*PRIO_W-1:0] RST_PRIO = 4'h0;

	typedef enum logic {
		BUS_IDLE,
		BUS_ACK
	} epsr_bus_t;

endpackage

//--- core/epsr_pend_find.sv
// highest priority pending enabled exception search
`timescale 1ns/10ps
module epsr_pend_find (
	// system exceptions
	input  wire logic                                       dsv_pending,
	input  wire logic [epsr_pkg::PRIO_W-1:0]                dsv_prio,
	input  wire logic                                       tick_pending,
	input  wire logic [epsr_pkg::PRIO_W-1:0]                tick_prio,
	// external interrupts
	input  wire logic [epsr_pkg::EXT_IRQS-1:0]              ext_pending,
	input  wire logic [epsr_pkg::EXT_IRQS-1:0]              ext_enable,
	input  wire logic [epsr_pkg::EXT_IRQS*epsr_pkg::PRIO_W-1:0] ext_priority,
	// result
	output logic [epsr_pkg::EXC_NUM_W-1:0]                  high_num
);
	import epsr_pkg::*;

	// one wider than a priority so "nothing found" loses every compare
	logic [PRIO_W:0] best;

	// lower number wins a tie: scan upward with strict compare
	always_comb begin
		best = {1'b1, {PRIO_W{1'b0}}};
		high_num = EXC_NONE;
		if (dsv_pending) begin
			best = {1'b0, dsv_prio};
			high_num = EXC_DSV;
		end
		if (tick_pending && ({1'b0, tick_prio} < best)) begin
			best = {1'b0, tick_prio};
			high_num = EXC_TICK;
		end
		for (int i = 0; i < EXT_IRQS; i++) begin
			if (ext_pending[i] && ext_enable[i] && ({1'b0, ext_priority[i*PRIO_W +: PRIO_W]} < best)) begin
				best = {1'b0, ext_priority[i*PRIO_W +: PRIO_W]};
				high_num = EXC_EXT_BASE + 6'(i);
			end
		end
	end

endmodule

//--- core/epsr_ctrl.sv
// interrupt control and state register with wishbone slave and event interrupt
`timescale 1ns/10ps
module epsr_ctrl (
	// clock and reset
	input  wire logic                                           clk_sys,
	input  wire logic                                           resetn,
	// wishbone slave
	input  wire logic                                           wb_cyc_i,
	input  wire logic                                           wb_stb_i,
	input  wire logic                                           wb_we_i,
	input  wire logic [3:0]                                     wb_adr_i,
	input  wire logic [3:0]                                     wb_sel_i,
	input  wire logic [31:0]                                    wb_dat_i,
	output logic      [31:0]                                    wb_dat_o,
	output logic                                                wb_ack_o,
	// core exception logic
	input  wire logic                                           tick_event,
	input  wire logic                                           core_take_dsv,
	input  wire logic                                           core_take_tick,
	input  wire logic [epsr_pkg::EXC_NUM_W-1:0]                 program_status_exception_number,
	input  wire logic [epsr_pkg::EXT_IRQS-1:0]                  ext_pending,
	input  wire logic [epsr_pkg::EXT_IRQS-1:0]                  ext_enable,
	input  wire logic [epsr_pkg::EXT_IRQS*epsr_pkg::PRIO_W-1:0] ext_priority,
	// state toward the core
	output logic                                                deferred_service_pending,
	output logic                                                system_tick_pending,
	output logic                                                any_interrupt_pending_flag,
	output logic      [epsr_pkg::EXC_NUM_W-1:0]                 highest_pending_exception_number,
	output logic      [epsr_pkg::EXC_NUM_W-1:0]                 active_exception_number,
	output logic      [4:0]                                     active_irq_index,
	output logic                                                active_irq_valid,
	// interrupt
	output logic                                                irq
);
	import epsr_pkg::*;

	// write of a one to bit pos with its byte lane enabled
	function automatic logic wr_one(input logic [3:0] sel, input logic [31:0] dat, input int unsigned pos);
		wr_one = sel[pos/8] & dat[pos];
	endfunction

	// byte lane of a field is enabled
	function automatic logic lane_on(input logic [3:0] sel, input int unsigned pos);
		lane_on = sel[pos/8];
	endfunction

	epsr_bus_t                  bus_state;
	logic                       bus_req;
	logic                       wr_ics;
	logic                       wr_status;
	logic                       wr_mask;
	logic                       wr_prio;
	logic                       sw_dsv_set;
	logic                       sw_dsv_clr;
	logic                       sw_tick_set;
	logic                       sw_tick_clr;
	logic [EV_W-1:0]            ev_status;
	logic [EV_W-1:0]            ev_mask;
	logic [EV_W-1:0]            ev_raise;
	logic [2*PRIO_W-1:0]        prio;
	logic [EXC_NUM_W-1:0]       next_high;
	logic                       next_any;
	logic [EXC_NUM_W-1:0]       next_irq_num;
	logic [31:0]                next_rdata;

	// request accepted once; ack drops the cycle after it is given
	assign bus_req = wb_cyc_i & wb_stb_i & (bus_state == BUS_IDLE);

	assign wr_ics    = bus_req & wb_we_i & (wb_adr_i == OFS_ICS);
	assign wr_status = bus_req & wb_we_i & (wb_adr_i == OFS_STATUS);
	assign wr_mask   = bus_req & wb_we_i & (wb_adr_i == OFS_MASK);
	assign wr_prio   = bus_req & wb_we_i & (wb_adr_i == OFS_PRIO);

	assign sw_dsv_set  = wr_ics & wr_one(wb_sel_i, wb_dat_i, BIT_DSV_SET);
	assign sw_dsv_clr  = wr_ics & wr_one(wb_sel_i, wb_dat_i, BIT_DSV_CLR);
	assign sw_tick_set = wr_ics & wr_one(wb_sel_i, wb_dat_i, BIT_TICK_SET);
	assign sw_tick_clr = wr_ics & wr_one(wb_sel_i, wb_dat_i, BIT_TICK_CLR);

	// bus handshake
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bus_state <= BUS_IDLE;
			wb_ack_o <= 1'b0;
		end else begin
			case (bus_state)
				BUS_IDLE: begin
					if (wb_cyc_i && wb_stb_i) begin
						bus_state <= BUS_ACK;
						wb_ack_o <= 1'b1;
					end
				end
				BUS_ACK: begin
					bus_state <= BUS_IDLE;
					wb_ack_o <= 1'b0;
				end
				default: begin
					bus_state <= BUS_IDLE;
					wb_ack_o <= 1'b0;
				end
			endcase
		end
	end

	// deferred service pending: only software sets it, core entry or software clears.
	// set wins over any clear in the same cycle, also when software
	// illegally writes both bits together
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			deferred_service_pending <= 1'b0;
		end else if (sw_dsv_set) begin
			deferred_service_pending <= 1'b1;
		end else if (sw_dsv_clr || core_take_dsv) begin
			deferred_service_pending <= 1'b0;
		end
	end

	// tick pending: timer event or software sets, core entry or software clears
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			system_tick_pending <= 1'b0;
		end else if (sw_tick_set || tick_event) begin
			system_tick_pending <= 1'b1;
		end else if (sw_tick_clr || core_take_tick) begin
			system_tick_pending <= 1'b0;
		end
	end

	// priorities of the two system exceptions
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prio <= RST_PRIO;
		end else if (wr_prio && lane_on(wb_sel_i, POS_PRIO_DSV)) begin
			prio <= wb_dat_i[2*PRIO_W-1:0];
		end
	end

	// search uses the registered pending bits, so the field lags a set by one cycle
	epsr_pend_find u_find (
		.dsv_pending  (deferred_service_pending),
		.dsv_prio     (prio[POS_PRIO_DSV +: PRIO_W]),
		.tick_pending (system_tick_pending),
		.tick_prio    (prio[POS_PRIO_TICK +: PRIO_W]),
		.ext_pending  (ext_pending),
		.ext_enable   (ext_enable),
		.ext_priority (ext_priority),
		.high_num     (next_high)
	);

	// disabled external interrupts still count; fault and nmi never reach this block
	assign next_any = (|ext_pending) | deferred_service_pending | system_tick_pending;

	assign next_irq_num = program_status_exception_number - EXC_EXT_BASE;

	// state reported to the core and into the register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			highest_pending_exception_number <= EXC_NONE;
			any_interrupt_pending_flag <= 1'b0;
			active_exception_number <= EXC_NONE;
			active_irq_index <= 5'h00;
			active_irq_valid <= 1'b0;
		end else begin
			highest_pending_exception_number <= next_high;
			any_interrupt_pending_flag <= next_any;
			active_exception_number <= program_status_exception_number;
			active_irq_index <= next_irq_num[4:0];
			active_irq_valid <= program_status_exception_number >= EXC_EXT_BASE;
		end
	end

	// sticky events
	assign ev_raise[EV_TICK_SET]   = (sw_tick_set | tick_event) & ~system_tick_pending;
	assign ev_raise[EV_DSV_SET]    = sw_dsv_set & ~deferred_service_pending;
	assign ev_raise[EV_ACTIVE_CHG] = program_status_exception_number != active_exception_number;

	// write one clears; a new event in the clearing cycle keeps the bit set
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ev_status <= '0;
		end else if (wr_status && lane_on(wb_sel_i, EV_TICK_SET)) begin
			ev_status <= (ev_status & ~wb_dat_i[EV_W-1:0]) | ev_raise;
		end else begin
			ev_status <= ev_status | ev_raise;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ev_mask <= RST_MASK;
		end else if (wr_mask && lane_on(wb_sel_i, EV_TICK_SET)) begin
			ev_mask <= wb_dat_i[EV_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(ev_status & ev_mask);
		end
	end

	// read data; reserved bits, write-only bits and unmapped offsets read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (wb_adr_i)
			OFS_ICS: begin
				next_rdata[BIT_DSV_SET] = deferred_service_pending;
				next_rdata[BIT_TICK_SET] = system_tick_pending;
				next_rdata[BIT_TICK_CLR] = 1'b0;
				next_rdata[BIT_ANY_PEND] = any_interrupt_pending_flag;
				next_rdata[POS_HIGH_PEND +: EXC_NUM_W] = highest_pending_exception_number;
				next_rdata[POS_ACTIVE +: EXC_NUM_W] = active_exception_number;
			end
			OFS_STATUS: begin
				next_rdata[EV_W-1:0] = ev_status;
			end
			OFS_MASK: begin
				next_rdata[EV_W-1:0] = ev_mask;
			end
			OFS_PRIO: begin
				next_rdata[2*PRIO_W-1:0] = prio;
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= next_rdata;
		end
	end

endmodule

//--- tb/epsr_ctrl_chk.sv
// assertion checker for the interrupt control and state register
`timescale 1ns/10ps
module epsr_ctrl_chk (
	// clock, reset, bus
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	// core side
	input wire logic        tick_event,
	input wire logic        core_take_tick,
	input wire logic [5:0]  program_status_exception_number,
	input wire logic [31:0] ext_pending,
	input wire logic [31:0] ext_enable,
	input wire logic        deferred_service_pending,
	input wire logic        system_tick_pending,
	input wire logic        any_interrupt_pending_flag,
	input wire logic [5:0]  highest_pending_exception_number,
	input wire logic [5:0]  active_exception_number,
	input wire logic [4:0]  active_irq_index,
	input wire logic        active_irq_valid,
	input wire logic        irq
);
	import epsr_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic wr, no_pend, only_tick, any_src;
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & (wb_adr_i == OFS_ICS) & wb_sel_i[3];
	assign no_pend = !deferred_service_pending & !system_tick_pending & !(|(ext_pending & ext_enable));
	assign only_tick = !deferred_service_pending & system_tick_pending & !(|(ext_pending & ext_enable));
	assign any_src = deferred_service_pending | system_tick_pending | (|ext_pending);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	a_tick_set:
		assert property (wr && wb_dat_i[BIT_TICK_SET] |=> system_tick_pending) else $error("tick not set");
	a_tick_hold:
		assert property (wr && !wb_dat_i[BIT_TICK_SET] && !wb_dat_i[BIT_TICK_CLR] && !tick_event && !core_take_tick
			|=> $stable(system_tick_pending)) else $error("tick changed by zero write");
	a_tick_clear:
		assert property (wr && wb_dat_i[BIT_TICK_CLR] && !wb_dat_i[BIT_TICK_SET] && !tick_event
			|=> !system_tick_pending) else $error("tick not cleared");
	a_dsv_set:
		assert property (wr && wb_dat_i[BIT_DSV_SET] |=> deferred_service_pending) else $error("deferred not set");
	a_dsv_clear:
		assert property (wr && wb_dat_i[BIT_DSV_CLR] && !wb_dat_i[BIT_DSV_SET]
			|=> !deferred_service_pending) else $error("deferred not cleared");
	a_any_flag:
		assert property (any_interrupt_pending_flag == $past(any_src)) else $error("any pending flag wrong");
	a_none_pend:
		assert property ($past(no_pend) |-> highest_pending_exception_number == EXC_NONE) else $error("ghost pending");
	a_tick_high:
		assert property ($past(only_tick) |-> highest_pending_exception_number == EXC_TICK) else $error("tick not high");
	a_active_copy:
		assert property (active_exception_number == $past(program_status_exception_number))
			else $error("active number wrong");
	a_irq_index:
		assert property (active_irq_valid == (active_exception_number >= EXC_EXT_BASE) && (!active_irq_valid
			|| active_irq_index == 5'(active_exception_number - EXC_EXT_BASE))) else $error("irq index wrong");
	c_irq: cover property (irq);
	c_ext: cover property (active_irq_valid);
	c_dclr: cover property (wr && wb_dat_i[BIT_DSV_CLR]);
endmodule
bind epsr_ctrl epsr_ctrl_chk epsr_ctrl_chk_i (.clk_sys, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_ack_o, .tick_event, .core_take_tick, .program_status_exception_number,
	.ext_pending, .ext_enable, .deferred_service_pending, .system_tick_pending, .any_interrupt_pending_flag,
	.highest_pending_exception_number, .active_exception_number, .active_irq_index, .active_irq_valid, .irq);

//--- tb/epsr_core_model.sv
// behavioural core exception entry model
`timescale 1ns/10ps
module epsr_core_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// bench control
	input  wire logic       run,
	input  wire logic [5:0] thread_num,
	// block side
	input  wire logic       dsv_pend,
	input  wire logic       tick_pend,
	output logic            take_dsv,
	output logic            take_tick,
	output logic      [5:0] exc_num
);
	import epsr_pkg::*;
	logic go_dsv, go_tick;
	// guards stop a second entry while the clear is still in flight
	assign go_dsv = run & dsv_pend & !take_dsv & !take_tick;
	assign go_tick = run & tick_pend & !dsv_pend & !take_tick;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			take_dsv  <= 1'b0;
			take_tick <= 1'b0;
			exc_num   <= EXC_NONE;
		end else begin
			take_dsv  <= go_dsv;
			take_tick <= go_tick;
			if (!run) exc_num <= thread_num;
			else if (go_dsv) exc_num <= EXC_DSV;
			else if (go_tick) exc_num <= EXC_TICK;
		end
	end
endmodule

//--- tb/tb_epsr_ctrl.sv
// self-checking bench for the interrupt control and state register
`timescale 1ns/10ps
module tb_epsr_ctrl;
	import epsr_pkg::*;
	localparam logic [31:0] TS = 32'h0400_0000, TC = 32'h0200_0000, DS = 32'h1000_0000, DC = 32'h0800_0000;
	localparam logic [31:0] ANY = 32'h0040_0000, RSV = 32'h01bc_0fc0;
	logic        clk_sys = 1'b0, resetn = 1'b0, cyc = 1'b0, we = 1'b0, tev = 1'b0, run = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] dw = 32'h0, extp = 32'h0, exte = 32'h0, dr, rd;
	logic [63:0] prio = 64'h0;
	logic [5:0]  tnum = 6'h00, psn, hnum, anum;
	logic [4:0]  iidx;
	logic        ack, tdsv, ttick, dsvp, tickp, anyp, ivalid, irq;
	int          n_errors = 0, n_tests = 0;

	always #4 clk_sys = ~clk_sys;

	epsr_ctrl epsr_ctrl_i (.clk_sys, .resetn, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .tick_event(tev), .core_take_dsv(tdsv),
		.core_take_tick(ttick), .program_status_exception_number(psn), .ext_pending(extp), .ext_enable(exte),
		.ext_priority(prio), .deferred_service_pending(dsvp), .system_tick_pending(tickp),
		.any_interrupt_pending_flag(anyp), .highest_pending_exception_number(hnum),
		.active_exception_number(anum), .active_irq_index(iidx), .active_irq_valid(ivalid), .irq);
	epsr_core_model epsr_core_model_i (.clk_sys, .resetn, .run, .thread_num(tnum), .dsv_pend(dsvp),
		.tick_pend(tickp), .take_dsv(tdsv), .take_tick(ttick), .exc_num(psn));

	task automatic give_verdict;
		if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		cyc <= 1'b1;
		we  <= w;
		adr <= a;
		dw  <= d;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (ack !== 1'b1 && i < 20);
		rd = dr;
		cyc <= 1'b0;
		we  <= 1'b0;
		// a lost ack ends the run here, nothing after the verdict
		if (ack !== 1'b1) begin
			n_errors++;
			give_verdict();
		end
	endtask
	// bit 25 is masked out, its read value is not defined
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rd & ~TC, e);
	endtask
	function automatic logic [31:0] hp(input logic [5:0] n);
		return {14'h0, n, 12'h0};
	endfunction

	task automatic t_reset;
		rchk(OFS_ICS, 32'h0);
		rchk(OFS_STATUS, 32'h0);
		rchk(OFS_MASK, 32'h0);
		rchk(OFS_PRIO, 32'h0);
		rchk(4'h2, 32'h0);
	endtask
	task automatic t_pend;
		wb(1'b1, OFS_ICS, TS | RSV);
		rchk(OFS_ICS, TS | ANY | hp(EXC_TICK));
		wb(1'b1, OFS_ICS, 32'h0);
		rchk(OFS_ICS, TS | ANY | hp(EXC_TICK));
		wb(1'b1, OFS_ICS, TC);
		rchk(OFS_ICS, 32'h0);
		wb(1'b1, OFS_ICS, DS);
		rchk(OFS_ICS, DS | ANY | hp(EXC_DSV));
		wb(1'b1, OFS_ICS, DC);
		rchk(OFS_ICS, 32'h0);
	endtask
	task automatic t_irq;
		wb(1'b1, OFS_STATUS, 32'h7);
		wb(1'b1, OFS_MASK, 32'h1);
		@(posedge clk_sys) tev <= 1'b1;
		@(posedge clk_sys) tev <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk(irq, 1'b1);
		rchk(OFS_STATUS, 32'h1);
		wb(1'b1, OFS_MASK, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk(irq, 1'b0);
		wb(1'b1, OFS_MASK, 32'h1);
		wb(1'b1, OFS_STATUS, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk(irq, 1'b0);
		wb(1'b1, OFS_ICS, TC);
	endtask
	task automatic t_core;
		wb(1'b1, OFS_ICS, DS | TS);
		rchk(OFS_ICS, DS | TS | ANY | hp(EXC_DSV));
		// deferred demoted below tick, so tick must now win
		wb(1'b1, OFS_PRIO, 32'h1);
		rchk(OFS_PRIO, 32'h1);
		rchk(OFS_ICS, DS | TS | ANY | hp(EXC_TICK));
		@(posedge clk_sys) run <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk(anum, EXC_TICK);
		rchk(OFS_ICS, {26'h0, EXC_TICK});
		// both set events and the active change were latched
		rchk(OFS_STATUS, 32'h7);
		@(posedge clk_sys) run <= 1'b0;
	endtask
	task automatic t_ext;
		@(posedge clk_sys) begin
			extp <= 32'h28;
			exte <= 32'h28;
			prio <= 64'h40;
			tnum <= 6'h15;
		end
		repeat (3) @(posedge clk_sys);
		chk({ivalid, iidx}, 6'h25);
		rchk(OFS_ICS, ANY | hp(6'h15) | 32'h15);
		@(posedge clk_sys) exte <= 32'h0;
		rchk(OFS_ICS, ANY | 32'h15);
	endtask

	initial begin
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_pend();
		t_irq();
		t_core();
		t_ext();
		give_verdict();
	end
endmodule
